// >>> rtl/rmc_pkg.sv
package rmc_pkg;
  // Active level of every ground-true line
  localparam logic ACTIVE_LOW = 1'b0;
  // Synchroniser depth
  localparam int SYNC_STAGES = 2;
  // Wishbone register offsets
  localparam logic [3:0] RMC_CTRL_OFS = 4'h0;
  localparam logic [3:0] RMC_STAT_OFS = 4'h4;
  // CTRL fields
  localparam int CTRL_PANEL_STOP_BIT = 0;
  localparam int CTRL_PANEL_LOAD_BIT = 1;
  localparam int CTRL_PANEL_FIT_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // STAT fields
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_LOAD_BIT = 1;
  localparam int STAT_PRESENT_BIT = 2;
  localparam int STAT_STEP_BIT = 3;
  localparam int STAT_PC_LSB = 16;
  typedef enum logic [1:0] {
    RMC_IDLE,
    RMC_ARMED
  } rmc_start_t;
  typedef enum logic [1:0] {
    RMC_HALTED,
    RMC_RUNNING,
    RMC_STEP,
    RMC_LOAD
  } rmc_mode_t;
endpackage

// >>> rtl/rmc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rmc_sync import rmc_pkg::*; #(
  parameter int WIDTH = 6,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] stab_q;
  logic [WIDTH-1:0] stab_d;

  always_comb begin
    meta_d = async_i;
    stab_d = meta_q;
  end

  // Two-stage capture
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      meta_q <= RESET_VAL;
      stab_q <= RESET_VAL;
    end else begin
      meta_q <= meta_d;
      stab_q <= stab_d;
    end
  end

  assign sync_o = stab_q;
endmodule
`default_nettype wire

// >>> rtl/rmc_core.sv
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Function
// - All control inputs are ground true
// - Clear resets program counter, overflow, control (the control register is kept; clear resets the mode and start state)
// - Halt request finishes current instruction first
// - Run needs halt line and panel both run
// - Start with run fetches at program counter
// - Start with load enters load mode
// - Start with neither executes one instruction
// - Presence line low marks remote control attached
// - Start fires when closed contact goes low
// - Single-contact bounce gives no extra start
// - Running indicator low while running or stepping
module rmc_core import rmc_pkg::*; #(
  parameter int PC_WIDTH = 13
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic clear_input_n_i,
  input wire logic halt_request_n_i,
  input wire logic load_request_n_i,
  input wire logic start_contact_no_n_i,
  input wire logic start_contact_nc_i,
  input wire logic remote_present_n_i,
  input wire logic instr_done_i,
  input wire logic load_done_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic running_indicator_n_o,
  output logic load_mode_bus_n_o,
  output logic exec_enable_o,
  output logic fetch_start_o,
  output logic [PC_WIDTH-1:0] pc_o,
  output logic overflow_o,
  output logic remote_attached_o
);
  localparam int NIN = 6;
  localparam int I_CLR = 0;
  localparam int I_HLT = 1;
  localparam int I_LD = 2;
  localparam int I_NO = 3;
  localparam int I_NC = 4;
  localparam int I_PR = 5;

  logic [NIN-1:0] raw;
  logic [NIN-1:0] syn;
  logic clr_act;
  logic halt_act;
  logic load_act;
  logic no_act;
  logic nc_act;
  logic pres_act;
  logic run_cond;
  logic load_cond;
  logic start_fire;
  logic bus_rd;
  logic bus_wr;
  logic bus_hit;

  function automatic logic active(input logic line);
    active = (line == ACTIVE_LOW);
  endfunction

  assign raw = {remote_present_n_i, start_contact_nc_i, start_contact_no_n_i,
                load_request_n_i, halt_request_n_i, clear_input_n_i};

  rmc_sync #(
    .WIDTH(NIN),
    .RESET_VAL({NIN{1'b1}})
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .async_i(raw),
    .sync_o(syn)
  );

  always_comb begin
    clr_act = active(syn[I_CLR]);
    halt_act = active(syn[I_HLT]);
    load_act = active(syn[I_LD]);
    no_act = active(syn[I_NO]);
    nc_act = active(syn[I_NC]);
    pres_act = active(syn[I_PR]);
  end

  // Control register
  logic [2:0] ctrl_q;
  logic [2:0] ctrl_d;
  logic ack_q;
  logic ack_d;
  logic err_q;
  logic err_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;

  // Start and mode state
  rmc_start_t st_q;
  rmc_start_t st_d;
  rmc_mode_t mode_q;
  rmc_mode_t mode_d;
  logic step_seen_q;
  logic step_seen_d;
  logic fetch_q;
  logic fetch_d;
  logic [PC_WIDTH-1:0] pc_q;
  logic [PC_WIDTH-1:0] pc_d;
  logic ovf_q;
  logic ovf_d;

  always_comb begin
    run_cond = !halt_act &&
               !(ctrl_q[CTRL_PANEL_FIT_BIT] && ctrl_q[CTRL_PANEL_STOP_BIT]);
    load_cond = load_act ||
                (ctrl_q[CTRL_PANEL_FIT_BIT] && ctrl_q[CTRL_PANEL_LOAD_BIT]);
  end

  // Start sequence: arm on NO contact closed with NC open, fire on NC closing
  always_comb begin
    st_d = st_q;
    start_fire = 1'b0;
    case (st_q)
      RMC_IDLE: begin
        if (pres_act && no_act && !nc_act) begin
          st_d = RMC_ARMED;
        end
      end
      RMC_ARMED: begin
        // NO contact bounce keeps arming only; a single fire per cycle of switch
        if (nc_act) begin
          start_fire = 1'b1;
          st_d = RMC_IDLE;
        end
      end
      default: begin
        st_d = RMC_IDLE;
      end
    endcase
    if (clr_act) begin
      st_d = RMC_IDLE;
      start_fire = 1'b0;
    end
  end

  // Machine mode
  always_comb begin
    mode_d = mode_q;
    fetch_d = 1'b0;
    pc_d = pc_q;
    ovf_d = ovf_q;
    step_seen_d = step_seen_q;
    case (mode_q)
      RMC_HALTED: begin
        if (start_fire) begin
          if (load_cond) begin
            mode_d = RMC_LOAD;
          end else if (run_cond) begin
            mode_d = RMC_RUNNING;
            fetch_d = 1'b1;
          end else begin
            mode_d = RMC_STEP;
            fetch_d = 1'b1;
          end
        end
      end
      RMC_RUNNING: begin
        if (instr_done_i) begin
          pc_d = pc_q + {{(PC_WIDTH-1){1'b0}}, 1'b1};
          if (!run_cond) begin
            mode_d = RMC_HALTED;
          end
        end
      end
      RMC_STEP: begin
        if (instr_done_i) begin
          pc_d = pc_q + {{(PC_WIDTH-1){1'b0}}, 1'b1};
          step_seen_d = 1'b1;
          mode_d = RMC_HALTED;
        end
      end
      RMC_LOAD: begin
        if (load_done_i) begin
          mode_d = RMC_HALTED;
        end
      end
      default: begin
        mode_d = RMC_HALTED;
      end
    endcase
    if (clr_act) begin
      mode_d = RMC_HALTED;
      pc_d = '0;
      ovf_d = 1'b0;
      step_seen_d = (mode_q == RMC_STEP) && instr_done_i;
      fetch_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_q <= RMC_IDLE;
      mode_q <= RMC_HALTED;
      fetch_q <= 1'b0;
      pc_q <= '0;
      ovf_q <= 1'b0;
      step_seen_q <= 1'b0;
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      fetch_q <= fetch_d;
      pc_q <= pc_d;
      ovf_q <= ovf_d;
      step_seen_q <= step_seen_d;
    end
  end

  // Wishbone slave, one registered ack (err for unmapped address) per request
  always_comb begin
    bus_hit = (wb_adr_i[3:0] == RMC_CTRL_OFS) || (wb_adr_i[3:0] == RMC_STAT_OFS);
    bus_hit = bus_hit && (wb_adr_i[31:4] == 28'h0000000);
    bus_rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q && !err_q;
    bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && !err_q;
    ack_d = (bus_rd || bus_wr) && bus_hit;
    err_d = (bus_rd || bus_wr) && !bus_hit;
    ctrl_d = ctrl_q;
    if (bus_wr && bus_hit && wb_adr_i[3:0] == RMC_CTRL_OFS && wb_sel_i[0]) begin
      ctrl_d = wb_dat_i[2:0];
    end
    rdat_d = rdat_q;
    if (bus_rd && bus_hit) begin
      rdat_d = '0;
      if (wb_adr_i[3:0] == RMC_CTRL_OFS) begin
        rdat_d[2:0] = ctrl_q;
      end else begin
        rdat_d[STAT_RUN_BIT] = (mode_q == RMC_RUNNING);
        rdat_d[STAT_LOAD_BIT] = (mode_q == RMC_LOAD);
        rdat_d[STAT_PRESENT_BIT] = pres_act;
        rdat_d[STAT_STEP_BIT] = step_seen_q;
        rdat_d[STAT_PC_LSB +: PC_WIDTH] = pc_q;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ctrl_q <= CTRL_RESET;
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      ack_q <= ack_d;
      err_q <= err_d;
      rdat_q <= rdat_d;
    end
  end

  // Outputs
  logic run_ind_q;
  logic load_bus_q;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      run_ind_q <= 1'b1;
      load_bus_q <= 1'b1;
    end else begin
      run_ind_q <= !(mode_d == RMC_RUNNING || mode_d == RMC_STEP);
      load_bus_q <= !(mode_d == RMC_LOAD);
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = rdat_q;
  assign running_indicator_n_o = run_ind_q;
  assign load_mode_bus_n_o = load_bus_q;
  assign exec_enable_o = !run_ind_q;
  assign fetch_start_o = fetch_q;
  assign pc_o = pc_q;
  assign overflow_o = ovf_q;
  assign remote_attached_o = pres_act;
endmodule
`default_nettype wire

// >>> bench/rmc_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rmc_core_sva #(
  parameter int PC_WIDTH = 13
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic clear_input_n_i,
  input wire logic remote_present_n_i,
  input wire logic instr_done_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic running_indicator_n_o,
  input wire logic load_mode_bus_n_o,
  input wire logic exec_enable_o,
  input wire logic fetch_start_o,
  input wire logic [PC_WIDTH-1:0] pc_o,
  input wire logic overflow_o,
  input wire logic remote_attached_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  a_exec_tracks_ind: assert property (exec_enable_o == !running_indicator_n_o)
    else $error("exec enable mismatch");
  a_clear_resets: assert property ((!clear_input_n_i)[*3] |=>
    pc_o == '0 && !overflow_o && running_indicator_n_o) else $error("clear ignored");
  a_halt_at_done: assert property ($rose(running_indicator_n_o) |->
    $past(instr_done_i) || !$past(clear_input_n_i, 3)) else $error("stopped mid instruction");
  a_pc_counts: assert property (instr_done_i && !running_indicator_n_o && clear_input_n_i
    |=> pc_o == $past(pc_o) + 1'b1) else $error("pc not advanced");
  a_fetch_start: assert property (fetch_start_o == $fell(running_indicator_n_o))
    else $error("fetch pulse mismatch");
  a_load_not_run: assert property (!load_mode_bus_n_o |->
    running_indicator_n_o && !fetch_start_o) else $error("load and run together");
  a_present_seen: assert property ($stable(remote_present_n_i)[*3] ##0
    (!$past(srst_i) && !$past(srst_i, 2)) |-> remote_attached_o == !remote_present_n_i)
    else $error("presence mismatch");
  a_bus_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o ^ wb_err_o) else $error("no bus answer");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
endmodule
bind rmc_core rmc_core_sva #(
  .PC_WIDTH(PC_WIDTH)
) i_sva (
  .sys_clk_i(sys_clk_i),
  .srst_i(srst_i),
  .clear_input_n_i(clear_input_n_i),
  .remote_present_n_i(remote_present_n_i),
  .instr_done_i(instr_done_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o),
  .running_indicator_n_o(running_indicator_n_o),
  .load_mode_bus_n_o(load_mode_bus_n_o),
  .exec_enable_o(exec_enable_o),
  .fetch_start_o(fetch_start_o),
  .pc_o(pc_o),
  .overflow_o(overflow_o),
  .remote_attached_o(remote_attached_o)
);
`default_nettype wire

// >>> bench/rmc_panel.sv
`timescale 1ns/1ps
`default_nettype none
module rmc_panel (
  input wire logic sys_clk_i,
  output logic no_n_o,
  output logic nc_o,
  output logic present_n_o
);
  assign present_n_o = 1'b0;
  initial begin
    no_n_o = 1'b1;
    nc_o = 1'b0;
  end
  task automatic step(input logic no, input logic nc);
    @(posedge sys_clk_i);
    {no_n_o, nc_o} <= {no, nc};
    repeat (4) @(posedge sys_clk_i);
  endtask
  // Break before make, bounce on the closed NO contact only
  task automatic press(input int b);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    repeat (b) begin
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
    end
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
endmodule
`default_nettype wire

// >>> bench/rmc_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rmc_core_tb;
  logic sys_clk_i, srst_i, clr_n, halt_n, load_n, done, ldone, we, cyc, stb, e;
  logic [31:0] adr, dat, q;
  logic [3:0] sel;
  wire logic no_n, nc, pres_n, ack, err, run_n, ldb_n, ovf;
  wire logic [31:0] rd;
  wire logic [12:0] pc;
  int failures, checked, n;
  rmc_panel i_panel (.sys_clk_i(sys_clk_i), .no_n_o(no_n), .nc_o(nc), .present_n_o(pres_n));
  rmc_core i_dut (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .clear_input_n_i(clr_n),
    .halt_request_n_i(halt_n), .load_request_n_i(load_n), .start_contact_no_n_i(no_n),
    .start_contact_nc_i(nc), .remote_present_n_i(pres_n), .instr_done_i(done),
    .load_done_i(ldone), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rd), .wb_ack_o(ack), .wb_err_o(err),
    .running_indicator_n_o(run_n), .load_mode_bus_n_o(ldb_n), .exec_enable_o(),
    .fetch_start_o(), .pc_o(pc), .overflow_o(ovf), .remote_attached_o()
  );
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  function automatic logic [31:0] stat_exp(input bit r, l, s, input int p);
    return {3'h0, 13'(p), 12'h0, s, 1'b1, l, r};
  endfunction
  task automatic print_verdict();
    if (failures == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic [31:0] a, input logic [31:0] d, input logic w,
                    input logic [3:0] s = 4'hF);
    int i;
    @(posedge sys_clk_i);
    {adr, dat, we, sel, cyc, stb} <= {a, d, w, s, 2'b11};
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk_i);
      if (ack === 1'b1 || err === 1'b1) break;
    end
    q = rd;
    e = err;
    {cyc, stb} <= 2'b0;
    if (i == 20) begin
      failures++;
      print_verdict();
    end
  endtask
  task automatic waitv(input bit ld, input logic v);
    int i;
    for (i = 0; i < 60 && (ld ? ldb_n : run_n) !== v; i++) @(posedge sys_clk_i);
    if (i == 60) begin
      failures++;
      print_verdict();
    end
  endtask
  task automatic pulse(input bit l);
    @(posedge sys_clk_i);
    {done, ldone} <= {!l, l};
    @(posedge sys_clk_i);
    {done, ldone} <= 2'b0;
  endtask
  initial begin
    {srst_i, clr_n, halt_n, load_n} = 4'hF;
    {done, ldone, we, cyc, stb} = 5'h0;
    {adr, dat} = 64'h0;
    sel = 4'h0;
    void'($urandom(32'hC46A8D61));
    repeat (4) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    n = $urandom_range(7, 0);
    wb(32'h0, 32'(n), 1'b1);
    wb(32'h0, 32'h0, 1'b0);
    chk(q, 32'(n));
    wb(32'h8, 32'h0, 1'b0);
    chk(32'(e), 32'h1);
    wb(32'h0, 32'h7, 1'b1, 4'hE);
    wb(32'h0, 32'h0, 1'b0);
    chk(q, 32'(n));
    wb(32'h0, 32'h0, 1'b1);
    wb(32'h4, 32'h0, 1'b0);
    chk(q, stat_exp(0, 0, 0, 0));
    i_panel.press($urandom_range(3, 1));
    waitv(0, 1'b0);
    n = $urandom_range(6, 2);
    repeat (n) pulse(0);
    repeat (2) @(posedge sys_clk_i);
    chk(32'(pc), 32'(n));
    halt_n <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    chk(32'(run_n), 32'h0);
    pulse(0);
    waitv(0, 1'b1);
    halt_n <= 1'b1;
    wb(32'h0, 32'h5, 1'b1);
    i_panel.press(0);
    waitv(0, 1'b0);
    pulse(0);
    waitv(0, 1'b1);
    wb(32'h4, 32'h0, 1'b0);
    chk(q, stat_exp(0, 0, 1, n + 2));
    wb(32'h0, 32'h0, 1'b1);
    halt_n <= 1'b0;
    load_n <= 1'b0;
    i_panel.press(1);
    waitv(1, 1'b0);
    wb(32'h4, 32'h0, 1'b0);
    chk(q, stat_exp(0, 1, 1, n + 2));
    pulse(1);
    waitv(1, 1'b1);
    load_n <= 1'b1;
    clr_n <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    chk(32'({ovf, pc}), 32'h0);
    clr_n <= 1'b1;
    print_verdict();
  end
endmodule
`default_nettype wire
